// ===== hw/converter_fault_protection.sv
// Fault-protection sequencer: gate gating, fault timers and restart cycles
`timescale 1ns/10ps
`default_nettype none
module converter_fault_protection #(
  parameter int unsigned OPP_LIMIT      = fault_protect_pkg::OPP_CYCLES,
  parameter int unsigned RECOVERY_LIMIT = fault_protect_pkg::RECOVERY_CYCLES
) (
  input  wire logic                             clk_in,
  input  wire logic                             resetn_in,
  input  wire logic                             low_side_request_in,
  input  wire logic                             high_side_request_in,
  input  wire logic                             blanking_done_in,
  input  wire logic                             demag_interval_in,
  input  wire logic                             cs_above_1v2_in,
  input  wire logic                             cs_otp_enable_in,
  input  wire logic                             latch_mode_in,
  input  wire logic [fault_protect_pkg::MV_W-1:0] opp_level_high_in,
  input  wire logic [fault_protect_pkg::MV_W-1:0] opp_level_low_in,
  input  wire logic [fault_protect_pkg::MV_W-1:0] peak_current_command_in,
  input  wire logic                             aux_vs_above_2v5_in,
  input  wire logic                             aux_vs_below_2v4_in,
  input  wire logic                             aux_vs_below_0v5_in,
  input  wire logic                             vdd_off_in,
  input  wire logic                             vdd_on_in,
  input  wire logic                             ref_good_in,
  input  wire logic                             junction_hot_in,
  output var  logic                             low_side_gate_drive_out,
  output var  logic                             high_side_gate_drive_out,
  output var  logic                             run_bias_out,
  output var  logic [fault_protect_pkg::MV_W-1:0] over_power_threshold_out,
  output var  logic [fault_protect_pkg::MV_W-1:0] peak_current_ceiling_out,
  output var  logic [fault_protect_pkg::MV_W-1:0] peak_current_limited_out,
  output var  logic                             threshold_high_set_out,
  output var  logic                             opp_timer_active_out,
  output var  logic                             recovery_active_out,
  output var  logic                             latched_out,
  output var  logic                             switching_enabled_out,
  output var  logic [2:0]                       fault_cause_out
);
  import fault_protect_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  seq_state_t        state_reg;
  seq_state_t        state_next;
  fault_cause_t      cause_reg;
  fault_cause_t      cause_next;
  logic              running;
  logic              ls_next;
  logic              hs_next;
  logic              cycle_start;
  logic              otp_sample;
  logic              ocp_sample;
  logic              otp_hit;
  logic              ocp_hit;
  logic              cmd_above_opp;
  logic              opp_done;
  logic              recovery_done;
  logic              short_seen;
  logic              go_fault;
  logic [MV_W-1:0]   level_sel;
  logic [MV_W-1:0]   threshold_next;
  logic [PROD_W-1:0] ceiling_wide;
  logic [MV_W-1:0]   ceiling_next;

  assign running = (state_reg == ST_RUN);

  // ---------------------------------------------------------------
  // Gate drive
  // ---------------------------------------------------------------
  // Gated by the next state so no pulse leaves on the fault edge
  // gates only in run
  assign ls_next = (state_next == ST_RUN) && low_side_request_in;
  assign hs_next = (state_next == ST_RUN) && high_side_request_in && !low_side_request_in;

  assign cycle_start = ls_next && !low_side_gate_drive_out;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      low_side_gate_drive_out  <= 1'b0;
      high_side_gate_drive_out <= 1'b0;
    end else begin
      low_side_gate_drive_out  <= ls_next;
      high_side_gate_drive_out <= hs_next;
    end
  end

  // ---------------------------------------------------------------
  // Over-power threshold and peak limit
  // ---------------------------------------------------------------
  // threshold set hysteresis
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      threshold_high_set_out <= 1'b0;
    end else if (aux_vs_above_2v5_in) begin
      threshold_high_set_out <= 1'b1;
    end else if (aux_vs_below_2v4_in) begin
      threshold_high_set_out <= 1'b0;
    end
  end

  assign level_sel = threshold_high_set_out ? opp_level_high_in : opp_level_low_in;

  assign threshold_next = (level_sel > OPP_CAP_MV) ? OPP_CAP_MV : level_sel;

  assign ceiling_wide = PROD_W'((PROD_W'(over_power_threshold_out) * PROD_W'(CEIL_NUM)) / PROD_W'(CEIL_DEN));
  assign ceiling_next = ceiling_wide[MV_W-1:0];

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      over_power_threshold_out <= '0;
      peak_current_ceiling_out <= '0;
      peak_current_limited_out <= '0;
    end else begin
      over_power_threshold_out <= threshold_next;
      peak_current_ceiling_out <= ceiling_next;
      if (peak_current_command_in > ceiling_next) begin
        peak_current_limited_out <= ceiling_next;
      end else begin
        peak_current_limited_out <= peak_current_command_in;
      end
    end
  end

  assign cmd_above_opp = (peak_current_command_in > over_power_threshold_out);

  // ---------------------------------------------------------------
  // Cycle qualification
  // ---------------------------------------------------------------
  // over-temp sample with low side off; over-current sample after blanking
  assign otp_sample = cs_otp_enable_in && cs_above_1v2_in && !low_side_gate_drive_out && demag_interval_in;
  assign ocp_sample = cs_above_1v2_in && blanking_done_in && demag_interval_in;

  cycle_qualifier #(
    .COUNT          (OTP_CYCLES_Q)
  ) u_otp_qual (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .clear_in       (!running),
    .sample_in      (otp_sample),
    .cycle_start_in (cycle_start),
    .hit_out        (otp_hit)
  );

  cycle_qualifier #(
    .COUNT          (OCP_CYCLES_Q)
  ) u_ocp_qual (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .clear_in       (!running),
    .sample_in      (ocp_sample),
    .cycle_start_in (cycle_start),
    .hit_out        (ocp_hit)
  );

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  // over-power timer
  fault_timer #(
    .LIMIT     (OPP_LIMIT)
  ) u_opp_timer (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .enable_in (running && cmd_above_opp),
    .done_out  (opp_done)
  );

  fault_timer #(
    .LIMIT     (RECOVERY_LIMIT)
  ) u_rec_timer (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .enable_in (state_reg == ST_RECOVERY),
    .done_out  (recovery_done)
  );

  assign short_seen = cmd_above_opp || aux_vs_below_0v5_in;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  assign go_fault = otp_hit || ocp_hit || opp_done;

  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    case (state_reg)
      ST_CHARGE: begin
        if (vdd_on_in) begin
          if (!ref_good_in || junction_hot_in) begin
            state_next = ST_UNDERVOLTAGE_LOCKOUT;
          end else begin
            state_next = ST_RUN;
            cause_next = CAUSE_NONE;
          end
        end
      end
      ST_RUN: begin
        if (!ref_good_in) begin
          state_next = ST_UNDERVOLTAGE_LOCKOUT;
          cause_next = CAUSE_REF;
        end else if (junction_hot_in) begin
          state_next = ST_UNDERVOLTAGE_LOCKOUT;
          cause_next = CAUSE_HOT;
        end else if (go_fault) begin
          state_next = latch_mode_in ? ST_LATCHED : ST_RECOVERY;
          if (ocp_hit) begin
            cause_next = CAUSE_OCP;
          end else if (otp_hit) begin
            cause_next = CAUSE_OTP;
          end else begin
            cause_next = CAUSE_OPP;
          end
        end else if (vdd_off_in) begin
          if (short_seen) begin
            state_next = latch_mode_in ? ST_LATCHED : ST_RECOVERY;
            cause_next = CAUSE_SCP;
          end else begin
            state_next = ST_CHARGE;
          end
        end
      end
      ST_UNDERVOLTAGE_LOCKOUT: begin
        if (vdd_off_in) begin
          state_next = ST_CHARGE;
        end
      end
      ST_RECOVERY: begin
        if (recovery_done) begin
          state_next = ST_WAIT_OFF;
        end
      end
      ST_WAIT_OFF: begin
        if (vdd_off_in) begin
          state_next = ST_CHARGE;
        end
      end
      ST_LATCHED: begin
        state_next = ST_LATCHED;
      end
      default: begin
        state_next = ST_UNDERVOLTAGE_LOCKOUT;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_reg <= ST_CHARGE;
      cause_reg <= CAUSE_NONE;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      run_bias_out          <= 1'b0;
      recovery_active_out   <= 1'b0;
      latched_out           <= 1'b0;
      switching_enabled_out <= 1'b0;
      opp_timer_active_out  <= 1'b0;
    end else begin
      run_bias_out          <= (state_next == ST_RUN);
      recovery_active_out   <= (state_next == ST_RECOVERY);
      latched_out           <= (state_next == ST_LATCHED);
      switching_enabled_out <= (state_next == ST_RUN);
      opp_timer_active_out  <= (state_next == ST_RUN) && cmd_above_opp;
    end
  end

  assign fault_cause_out = cause_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  hs_low_ls_a: assert property (
    low_side_gate_drive_out |-> !high_side_gate_drive_out)
    else $error("high side on during low-side on-time");

  no_pulse_fault_a: assert property (
    (recovery_active_out || latched_out) |-> !low_side_gate_drive_out)
    else $error("gate pulse during fault");

  ocp_bias_drop_a: assert property (
    (running && ocp_hit && ref_good_in && !junction_hot_in) |=> !run_bias_out ##1 !low_side_gate_drive_out)
    else $error("bias not dropped after over-current");

  ceiling_clamp_a: assert property (
    peak_current_limited_out <= peak_current_ceiling_out)
    else $error("limited command above ceiling");

  threshold_cap_a: assert property (
    over_power_threshold_out <= OPP_CAP_MV)
    else $error("threshold above cap");

  latch_hold_a: assert property (
    latched_out |=> latched_out && !switching_enabled_out)
    else $error("latch-off released");

  opp_clear_a: assert property (
    (running && !cmd_above_opp && $stable(over_power_threshold_out)) |=> !opp_timer_active_out)
    else $error("over-power timer not cleared");

  short_recover_a: assert property (
    (running && vdd_off_in && short_seen && !go_fault && ref_good_in && !junction_hot_in && !latch_mode_in)
      |=> recovery_active_out)
    else $error("short not sent to recovery");

  ref_shutdown_a: assert property (
    (running && !ref_good_in) |=> ##1 !low_side_gate_drive_out [*2])
    else $error("switching continued with reference low");

endmodule // converter_fault_protection
`default_nettype wire

// ===== hw/cycle_qualifier.sv
// Counts consecutive switching cycles in which a condition was seen
`timescale 1ns/10ps
`default_nettype none
module cycle_qualifier #(
  parameter int unsigned COUNT = 3
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic clear_in,
  input  wire logic sample_in,
  input  wire logic cycle_start_in,
  output var  logic hit_out
);
  import fault_protect_pkg::*;

  localparam logic [QUAL_W-1:0] TARGET = QUAL_W'(COUNT);

  logic              seen_reg;
  logic [QUAL_W-1:0] count_reg;

  // Condition seen anywhere in the present cycle
  always_ff @(posedge clk_in) begin
    if (!resetn_in || clear_in || cycle_start_in) begin
      seen_reg <= 1'b0;
    end else if (sample_in) begin
      seen_reg <= 1'b1;
    end
  end

  // A clean cycle breaks the run of consecutive hits
  always_ff @(posedge clk_in) begin
    if (!resetn_in || clear_in) begin
      count_reg <= '0;
    end else if (cycle_start_in) begin
      if (seen_reg || sample_in) begin
        if (count_reg != TARGET) begin
          count_reg <= count_reg + 1'b1;
        end
      end else begin
        count_reg <= '0;
      end
    end
  end

  assign hit_out = (count_reg == TARGET);

endmodule // cycle_qualifier
`default_nettype wire

// ===== hw/fault_timer.sv
// Enable-driven interval timer with a registered expiry flag
`timescale 1ns/10ps
`default_nettype none
module fault_timer #(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic enable_in,
  output var  logic done_out
);
  import fault_protect_pkg::*;

  localparam logic [TIMER_W-1:0] LAST = TIMER_W'(LIMIT - 1);

  logic [TIMER_W-1:0] count_reg;

  // Counts while enabled; dropping the enable clears it at once
  always_ff @(posedge clk_in) begin
    if (!resetn_in || !enable_in) begin
      count_reg <= '0;
      done_out  <= 1'b0;
    end else if (count_reg == LAST) begin
      done_out <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

endmodule // fault_timer
`default_nettype wire

// ===== shared/fault_protect_pkg.sv
// Constants and types shared by the converter fault-protection sequencer
// ---------------------------------------------------------------------
// How it works
// - Sensing-pin overtemp after two successive high samples
// - Overtemp auto-recovery waits out the recovery timer
// - Temperature sample only while low side off
// - High side held low during low-side on-time
// - Overtemp obeys auto-recovery or latch-off mode
// - Command above threshold starts over-power timer
// - Over-power timer expiry stops switching, starts recovery; code latches off instead in latch mode
// - Aux sense hysteresis selects threshold set
// - Over-power threshold capped at its highest level
// - Peak command ceiling is four thirds threshold
// - Plain supply restart when no short seen
// - Short indication at supply-off starts recovery; code latches off instead in latch mode
// - Three over-current cycles stop switching, drop bias
// - No test pulses while a fault holds
// - Restart at first supply-off after timeout
// - Reference power-good loss forces supply restart
// - Held-low reference keeps restarting, inhibits switching
// - Junction overtemp repeats supply restart cycles
// ---------------------------------------------------------------------
package fault_protect_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned NS_PER_MS        = 1000000;
  localparam int unsigned OPP_TIME_MS      = 160;
  localparam int unsigned RECOVERY_TIME_MS = 1500;
  localparam int unsigned OPP_CYCLES       = OPP_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned RECOVERY_CYCLES  = RECOVERY_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned TIMER_W          = 28;

  // Current-sense scale in millivolts
  localparam int unsigned         MV_W         = 11;
  localparam logic [MV_W-1:0]     OPP_CAP_MV   = 11'h258;
  localparam int unsigned         CEIL_NUM     = 4;
  localparam int unsigned         CEIL_DEN     = 3;
  localparam int unsigned         PROD_W       = MV_W + 3;

  // Consecutive switching cycles that qualify a fault
  localparam int unsigned QUAL_W       = 2;
  localparam int unsigned OTP_CYCLES_Q = 2;
  localparam int unsigned OCP_CYCLES_Q = 3;

  // Fault cause reported on the status port
  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_OTP,
    CAUSE_OPP,
    CAUSE_SCP,
    CAUSE_OCP,
    CAUSE_REF,
    CAUSE_HOT
  } fault_cause_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_CHARGE,
    ST_RUN,
    ST_UNDERVOLTAGE_LOCKOUT,
    ST_RECOVERY,
    ST_WAIT_OFF,
    ST_LATCHED
  } seq_state_t;

endpackage

// ===== testbench/power_stage_model.sv
// Power-stage model: modulator timing, sense resistor and thermistor comparator
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
  input  wire logic       clk_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       ls_gate_in,
  output var  logic       ls_req_out,
  output var  logic       hs_req_out,
  output var  logic       blank_done_out,
  output var  logic       demag_out,
  output var  logic       cs_high_out
);
  logic [3:0] phase_reg = 4'h0;
  // ----------------------------------------------------------------
  // Ten-cycle switching period, high side request overlaps low side
  // ----------------------------------------------------------------
  always_ff @(negedge clk_in) begin
    phase_reg <= (phase_reg == 4'h9) ? 4'h0 : phase_reg + 4'h1;
  end
  always_comb begin
    ls_req_out     = (phase_reg <= 4'h2);
    hs_req_out     = (phase_reg >= 4'h2) && (phase_reg <= 4'h6);
    blank_done_out = (phase_reg >= 4'h1) && (phase_reg <= 4'h3);
    demag_out      = (phase_reg <= 4'h6);
    // Mode 1 shorted sense, only while gate on; mode 2 hot thermistor, gate off
    cs_high_out    = ((mode_in == 2'd1) && ls_gate_in) || ((mode_in == 2'd2) && (phase_reg == 4'h5));
  end
endmodule // power_stage_model
`default_nettype wire

// ===== testbench/tb_converter_fault_protection.sv
// Self-checking testbench of the converter fault-protection sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_converter_fault_protection;
  import fault_protect_pkg::*;
  localparam int unsigned OPP_L = 20;
  localparam int unsigned REC_L = 50;
  logic        clk_in = 1'b0;
  logic        resetn = 1'b0, cs_otp_en = 1'b1, latch_mode = 1'b0, vdd_off = 1'b0, vdd_on = 1'b0;
  logic        above = 1'b1, below24 = 1'b0, below05 = 1'b0, ref_good = 1'b1, hot = 1'b0;
  logic [10:0] lvl_hi = 11'h2bc, lvl_lo = 11'h190, cmd = 11'h064;
  logic [1:0]  mode = 2'd0;
  logic        ls_req, hs_req, blank, demag, cs_hi;
  logic        ls_out, hs_out, bias, hi_set, opp_act, rec_act, latched, sw_en;
  logic [10:0] thr, ceil_v, lim;
  logic [2:0]  cause;
  int          miscompares = 0;
  int          total_checks = 0;

  initial begin
    forever #4 clk_in = ~clk_in;
  end

  power_stage_model model (.clk_in(clk_in), .mode_in(mode), .ls_gate_in(ls_out), .ls_req_out(ls_req),
    .hs_req_out(hs_req), .blank_done_out(blank), .demag_out(demag), .cs_high_out(cs_hi));

  converter_fault_protection #(.OPP_LIMIT(OPP_L), .RECOVERY_LIMIT(REC_L)) DUT (
    .clk_in(clk_in), .resetn_in(resetn), .low_side_request_in(ls_req), .high_side_request_in(hs_req),
    .blanking_done_in(blank), .demag_interval_in(demag), .cs_above_1v2_in(cs_hi),
    .cs_otp_enable_in(cs_otp_en), .latch_mode_in(latch_mode), .opp_level_high_in(lvl_hi),
    .opp_level_low_in(lvl_lo), .peak_current_command_in(cmd), .aux_vs_above_2v5_in(above),
    .aux_vs_below_2v4_in(below24), .aux_vs_below_0v5_in(below05), .vdd_off_in(vdd_off),
    .vdd_on_in(vdd_on), .ref_good_in(ref_good), .junction_hot_in(hot),
    .low_side_gate_drive_out(ls_out), .high_side_gate_drive_out(hs_out), .run_bias_out(bias),
    .over_power_threshold_out(thr), .peak_current_ceiling_out(ceil_v), .peak_current_limited_out(lim),
    .threshold_high_set_out(hi_set), .opp_timer_active_out(opp_act), .recovery_active_out(rec_act),
    .latched_out(latched), .switching_enabled_out(sw_en), .fault_cause_out(cause));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [10:0] seen, input logic [10:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic pulse(input bit on);
    if (on) vdd_on = 1'b1;
    else vdd_off = 1'b1;
    cyc(1);
    vdd_on = 1'b0;
    vdd_off = 1'b0;
    cyc(1);
  endtask

  task automatic wait_flag(input bit lat, input int lim_c, output int n);
    n = 0;
    while (((lat ? latched : rec_act) !== 1'b1) && (n < lim_c)) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic start_up;
    mode = 2'd0; cmd = 11'h064; ref_good = 1'b1; hot = 1'b0; latch_mode = 1'b0; cs_otp_en = 1'b1;
    above = 1'b1; below24 = 1'b0; below05 = 1'b0; lvl_hi = 11'h2bc; lvl_lo = 11'h190;
    resetn = 1'b0;
    cyc(16);
    resetn = 1'b1;
    chk("reset_bias", bias, 1'b0);
    chk("reset_cause", cause, 3'h0);
    cyc(1);
    pulse(1'b1);
    chk("start_bias", bias, 1'b1);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_gates;
    logic req;
    int   ovl, hs_seen;
    start_up();
    ovl = 0;
    hs_seen = 0;
    repeat (30) begin
      @(posedge clk_in);
      req = ls_req;
      @(negedge clk_in);
      chk("ls_gate", ls_out, req);
      if (ls_out === 1'b1 && hs_out !== 1'b0) ovl++;
      if (hs_out === 1'b1) hs_seen++;
    end
    chk("hs_overlap", 11'(ovl), 11'h0);
    chk("hs_seen", 11'(hs_seen != 0), 11'h1);
    $display("test gates done");
  endtask

  task automatic t_thr;
    start_up();
    cmd = 11'h3e8;
    cyc(3);
    chk("thr_cap", thr, 11'h258);
    chk("ceil_hi", ceil_v, 11'h320);
    chk("lim_hi", lim, 11'h320);
    cmd = 11'h064;
    above = 1'b0;
    cyc(3);
    chk("thr_hold", thr, 11'h258);
    below24 = 1'b1;
    cyc(3);
    chk("thr_low", thr, 11'h190);
    chk("set_low", hi_set, 1'b0);
    below24 = 1'b0;
    cmd = 11'h3e8;
    cyc(3);
    chk("thr_hold_low", thr, 11'h190);
    chk("ceil_low", ceil_v, 11'h215);
    chk("lim_low", lim, 11'h215);
    cmd = 11'h064;
    $display("test thresholds done");
  endtask

  task automatic t_ocp;
    int n, pulses;
    start_up();
    mode = 2'd1;
    wait_flag(1'b0, 60, n);
    chk("ocp_rec", rec_act, 1'b1);
    chk("ocp_cause", cause, 3'h4);
    chk("ocp_bias", bias, 1'b0);
    mode = 2'd0;
    pulses = 0;
    repeat (40) begin
      cyc(1);
      if (ls_out !== 1'b0) pulses++;
    end
    chk("ocp_pulses", 11'(pulses), 11'h0);
    pulse(1'b0);
    pulse(1'b1);
    chk("early_restart", bias, 1'b0);
    cyc(10);
    chk("rec_over", rec_act, 1'b0);
    pulse(1'b0);
    pulse(1'b1);
    chk("restart_bias", bias, 1'b1);
    $display("test over-current done");
  endtask

  task automatic t_otp;
    int n;
    start_up();
    cs_otp_en = 1'b0;
    mode = 2'd2;
    cyc(60);
    chk("otp_off", rec_act, 1'b0);
    cs_otp_en = 1'b1;
    wait_flag(1'b0, 40, n);
    chk("otp_rec", rec_act, 1'b1);
    chk("otp_cause", cause, 3'h1);
    chk("otp_sw", sw_en, 1'b0);
    chk("otp_latch", latched, 1'b0);
    $display("test over-temperature done");
  endtask

  task automatic t_latch;
    int n;
    start_up();
    latch_mode = 1'b1;
    mode = 2'd2;
    wait_flag(1'b1, 60, n);
    chk("latched", latched, 1'b1);
    mode = 2'd0;
    cyc(80);
    pulse(1'b0);
    pulse(1'b1);
    chk("latch_bias", bias, 1'b0);
    chk("latch_hold", latched, 1'b1);
    $display("test latch-off done");
  endtask

  task automatic t_opp;
    int n;
    start_up();
    cmd = 11'h262;
    cyc(2);
    chk("opp_start", opp_act, 1'b1);
    cyc(5);
    cmd = 11'h064;
    cyc(2);
    chk("opp_clear", opp_act, 1'b0);
    cyc(30);
    chk("opp_nofault", rec_act, 1'b0);
    cmd = 11'h262;
    wait_flag(1'b0, 60, n);
    chk("opp_time", 11'((n >= OPP_L) && (n <= OPP_L + 3)), 11'h1);
    chk("opp_cause", cause, 3'h2);
    chk("opp_sw", sw_en, 1'b0);
    $display("test over-power done");
  endtask

  task automatic t_scp;
    for (int k = 0; k < 3; k++) begin
      start_up();
      below05 = (k == 1);
      cmd = (k == 2) ? 11'h262 : 11'h064;
      cyc(2);
      pulse(1'b0);
      chk("scp_bias", bias, 1'b0);
      chk("scp_rec", rec_act, k != 0);
      if (k != 0) chk("scp_cause", cause, 3'h3);
      if (k == 0) begin
        pulse(1'b1);
        chk("plain_restart", bias, 1'b1);
      end
    end
    $display("test short-circuit done");
  endtask

  task automatic t_ext;
    for (int k = 0; k < 2; k++) begin
      start_up();
      if (k == 0) ref_good = 1'b0;
      else hot = 1'b1;
      cyc(2);
      chk("ext_bias", bias, 1'b0);
      chk("ext_sw", sw_en, 1'b0);
      chk("ext_cause", cause, (k == 0) ? 3'h5 : 3'h6);
      pulse(1'b0);
      pulse(1'b1);
      chk("ext_repeat", bias, 1'b0);
      ref_good = 1'b1;
      hot = 1'b0;
      pulse(1'b0);
      pulse(1'b1);
      chk("ext_release", bias, 1'b1);
    end
    $display("test shutdown done");
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    end_of_test();
  end

  initial begin
    t_gates();
    t_thr();
    t_ocp();
    t_otp();
    t_latch();
    t_opp();
    t_scp();
    t_ext();
    end_of_test();
  end
endmodule // tb_converter_fault_protection
`default_nettype wire
